// file: verilog/csmc_pkg.sv
// constants and carrier types for the coincident-select memory controller
// Notes on behaviour
// - a bit is chosen by its row and column lines high; others held low.
// - writing a one means selecting the location and raising the write-one strobe.
// - writing a zero means selecting the location and raising the write-zero strobe.
// - each write raises exactly one strobe, chosen by the data value.
// - sense outputs are open collector, wired-OR, with a pull-up on each node.
// - each strobe lasts at least 100 ns; data settles 35 ns after it falls.
package csmc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // matrix geometry
    localparam int ROWS      = 4;
    localparam int COLS      = 4;
    localparam int WORDS     = 16;
    localparam int ADDR_W    = 4;
    localparam int ROW_LSB   = 2;
    localparam int CNT_W     = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // timing, figures in ns and derived cycle counts at MCLK
    localparam int CLK_NS     = 4;
    localparam int STROBE_NS  = 100;
    localparam int SETTLE_NS  = 35;
    localparam int SETUP_NS   = 20;   // address set-up before a strobe
    localparam int ACCESS_NS  = 100;  // select to sense valid, plus margin
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC  = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

    ////////////////////////////////////////////////////////////////////////////////
    // controller states
    typedef enum logic [2:0] {
        CSMC_IDLE   = 3'h0,
        CSMC_SETUP  = 3'h1,
        CSMC_STROBE = 3'h2,
        CSMC_SETTLE = 3'h3,
        CSMC_SENSE  = 3'h4
    } csmc_state_t;

    // pins driven toward the memory
    typedef struct packed {
        logic [ROWS-1:0] row;
        logic [COLS-1:0] col;
        logic            wr_one;
        logic            wr_zero;
    } csmc_pins_t;

    // one accepted command
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic              data;
    } csmc_cmd_t;

    // shadow entry: known flag and last written value
    typedef struct packed {
        logic known;
        logic value;
    } csmc_shadow_t;

endpackage : csmc_pkg

// file: verilog/csmc_shadow_mem.sv
// shadow copy of the words written, for read-back comparison
`timescale 1ns/1ns
module csmc_shadow_mem (
    input  wire logic                         MCLK,
    input  wire logic                         SRST,
    input  wire logic                         wr_en,
    input  wire logic [csmc_pkg::ADDR_W-1:0]  wr_addr,
    input  wire logic                         wr_value,
    input  wire logic [csmc_pkg::ADDR_W-1:0]  rd_addr,
    output      csmc_pkg::csmc_shadow_t       rd_data
);

    csmc_pkg::csmc_shadow_t mem_q [csmc_pkg::WORDS];
    csmc_pkg::csmc_shadow_t rd_q;

    ////////////////////////////////////////////////////////////////////////////////
    // one entry per word, cleared to unknown at reset
    for (genvar i = 0; i < csmc_pkg::WORDS; i++) begin : g_word
        always_ff @(posedge MCLK) begin
            if (SRST) begin
                mem_q[i] <= '0;
            end else if (wr_en && (wr_addr == csmc_pkg::ADDR_W'(i))) begin
                mem_q[i] <= '{known: 1'b1, value: wr_value};
            end
        end
    end

    // registered read port
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rd_q <= '0;
        end else begin
            rd_q <= mem_q[rd_addr];
        end
    end

    assign rd_data = rd_q;

endmodule : csmc_shadow_mem

// file: verilog/csmc_ctrl.sv
// controller that drives the coincident-select 16x1 memory through its pins
`timescale 1ns/1ns
module csmc_ctrl (
    input  wire logic                         MCLK,
    input  wire logic                         SRST,
    input  wire logic                         CMD_VALID,
    input  wire logic                         CMD_WRITE,
    input  wire logic [csmc_pkg::ADDR_W-1:0]  CMD_ADDR,
    input  wire logic                         CMD_DATA,
    output wire logic                         CMD_READY,
    output wire logic                         RSP_VALID,
    output wire logic                         RSP_DATA,
    output wire logic                         RSP_NONE,
    output wire logic                         RSP_MISMATCH,
    output wire logic [csmc_pkg::ROWS-1:0]    ROW_SEL,
    output wire logic [csmc_pkg::COLS-1:0]    COL_SEL,
    output wire logic                         WR_ONE,
    output wire logic                         WR_ZERO,
    input  wire logic                         SENSE_ONE_N,
    input  wire logic                         SENSE_ZERO_N
);

    localparam logic [csmc_pkg::CNT_W-1:0] STROBE_LD = csmc_pkg::CNT_W'(csmc_pkg::STROBE_CYC - 1);
    localparam logic [csmc_pkg::CNT_W-1:0] SETTLE_LD = csmc_pkg::CNT_W'(csmc_pkg::SETTLE_CYC - 1);
    localparam logic [csmc_pkg::CNT_W-1:0] SETUP_LD  = csmc_pkg::CNT_W'(csmc_pkg::SETUP_CYC - 1);
    localparam logic [csmc_pkg::CNT_W-1:0] ACCESS_LD = csmc_pkg::CNT_W'(csmc_pkg::ACCESS_CYC - 1);

    csmc_pkg::csmc_state_t   state_q;
    logic [csmc_pkg::CNT_W-1:0] cnt_q;
    csmc_pkg::csmc_cmd_t     cmd_q;
    csmc_pkg::csmc_pins_t    pins_q;
    csmc_pkg::csmc_shadow_t  shadow;
    logic                    ready_q;
    logic                    rsp_valid_q;
    logic                    rsp_data_q;
    logic                    rsp_none_q;
    logic                    rsp_mis_q;
    logic                    s1_m_q;
    logic                    s1_s_q;
    logic                    s0_m_q;
    logic                    s0_s_q;
    logic                    accept;
    logic                    cnt_done;
    logic                    shadow_we;

    assign accept    = CMD_VALID && ready_q;
    assign cnt_done  = (cnt_q == '0);
    assign shadow_we = (state_q == csmc_pkg::CSMC_STROBE) && cnt_done;

    ////////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers on the wired-OR sense nodes
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            s1_m_q <= 1'b1;
            s1_s_q <= 1'b1;
            s0_m_q <= 1'b1;
            s0_s_q <= 1'b1;
        end else begin
            s1_m_q <= SENSE_ONE_N;
            s1_s_q <= s1_m_q;
            s0_m_q <= SENSE_ZERO_N;
            s0_s_q <= s0_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer: setup, strobe, settle for writes; setup, sense wait for reads
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            state_q <= csmc_pkg::CSMC_IDLE;
            cnt_q   <= '0;
            ready_q <= 1'b0;
        end else begin
            case (state_q)
                csmc_pkg::CSMC_IDLE: begin
                    ready_q <= ~accept;
                    if (accept) begin
                        state_q <= csmc_pkg::CSMC_SETUP;
                        cnt_q   <= SETUP_LD;
                    end
                end
                csmc_pkg::CSMC_SETUP: begin
                    if (!cnt_done) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else if (cmd_q.write) begin
                        state_q <= csmc_pkg::CSMC_STROBE;
                        cnt_q   <= STROBE_LD;
                    end else begin
                        state_q <= csmc_pkg::CSMC_SENSE;
                        cnt_q   <= ACCESS_LD;
                    end
                end
                csmc_pkg::CSMC_STROBE: begin
                    if (!cnt_done) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= csmc_pkg::CSMC_SETTLE;
                        cnt_q   <= SETTLE_LD;
                    end
                end
                csmc_pkg::CSMC_SETTLE,
                csmc_pkg::CSMC_SENSE: begin
                    if (!cnt_done) begin
                        cnt_q <= cnt_q - 1'b1;
                    end else begin
                        state_q <= csmc_pkg::CSMC_IDLE;
                        ready_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= csmc_pkg::CSMC_IDLE;
                    ready_q <= 1'b1;
                end
            endcase
        end
    end

    // command capture
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cmd_q <= '0;
        end else if (accept) begin
            cmd_q <= '{write: CMD_WRITE, addr: CMD_ADDR, data: CMD_DATA};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin drive: one row and one column while busy, one strobe per write
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pins_q <= '0;
        end else begin
            if (state_q == csmc_pkg::CSMC_IDLE && accept) begin
                pins_q.row <= csmc_pkg::ROWS'(1) << CMD_ADDR[csmc_pkg::ADDR_W-1:csmc_pkg::ROW_LSB];
                pins_q.col <= csmc_pkg::COLS'(1) << CMD_ADDR[csmc_pkg::ROW_LSB-1:0];
            end else if ((state_q == csmc_pkg::CSMC_SETTLE || state_q == csmc_pkg::CSMC_SENSE) && cnt_done) begin
                pins_q.row <= '0;
                pins_q.col <= '0;
            end
            if (state_q == csmc_pkg::CSMC_SETUP && cnt_done && cmd_q.write) begin
                pins_q.wr_one  <= cmd_q.data;
                pins_q.wr_zero <= ~cmd_q.data;
            end else if (shadow_we) begin
                pins_q.wr_one  <= 1'b0;
                pins_q.wr_zero <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // answer: write done after settle, read sampled from the synced sense pair
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 1'b0;
            rsp_none_q  <= 1'b0;
            rsp_mis_q   <= 1'b0;
        end else begin
            rsp_valid_q <= 1'b0;
            if (state_q == csmc_pkg::CSMC_SETTLE && cnt_done) begin
                rsp_valid_q <= 1'b1;
                rsp_data_q  <= cmd_q.data;
                rsp_none_q  <= 1'b0;
                rsp_mis_q   <= 1'b0;
            end else if (state_q == csmc_pkg::CSMC_SENSE && cnt_done) begin
                rsp_valid_q <= 1'b1;
                rsp_data_q  <= ~s1_s_q & s0_s_q;   // one-sense low means a stored one
                rsp_none_q  <= s1_s_q & s0_s_q;    // both pulled up: nothing drove
                rsp_mis_q   <= (s1_s_q == s0_s_q) ||
                               (shadow.known && (shadow.value != ~s1_s_q));
            end
        end
    end

    csmc_shadow_mem u_shadow (
        .MCLK     (MCLK),
        .SRST     (SRST),
        .wr_en    (shadow_we),
        .wr_addr  (cmd_q.addr),
        .wr_value (cmd_q.data),
        .rd_addr  (cmd_q.addr),
        .rd_data  (shadow)
    );

    assign CMD_READY    = ready_q;
    assign RSP_VALID    = rsp_valid_q;
    assign RSP_DATA     = rsp_data_q;
    assign RSP_NONE     = rsp_none_q;
    assign RSP_MISMATCH = rsp_mis_q;
    assign ROW_SEL      = pins_q.row;
    assign COL_SEL      = pins_q.col;
    assign WR_ONE       = pins_q.wr_one;
    assign WR_ZERO      = pins_q.wr_zero;

    ////////////////////////////////////////////////////////////////////////////////
    // checks on the pins this controller drives
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    localparam int STROBE_MIN = csmc_pkg::STROBE_CYC;
    logic [csmc_pkg::CNT_W-1:0] width_q;
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            width_q <= '0;
        end else if (WR_ONE || WR_ZERO) begin
            width_q <= width_q + 1'b1;
        end else begin
            width_q <= '0;
        end
    end

    sequence write_taken_s;
        accept && CMD_WRITE;
    endsequence
    sequence write_done_s;
        RSP_VALID && !RSP_NONE;
    endsequence
    // one cycle in which neither select moved
    sequence sel_still_s;
        $stable(ROW_SEL) && $stable(COL_SEL);
    endsequence

    one_line_sel_a:    assert property ($onehot0(ROW_SEL) && $onehot0(COL_SEL))
        else $error("more than one row or column line high");
    strobe_has_sel_a:  assert property ((WR_ONE || WR_ZERO) |-> (ROW_SEL != '0 && COL_SEL != '0))
        else $error("write strobe without a selected location");
    strobes_apart_a:   assert property (!(WR_ONE && WR_ZERO))
        else $error("both write strobes high");
    strobe_value_a:    assert property ($rose(WR_ONE || WR_ZERO) |-> (WR_ONE == cmd_q.data))
        else $error("strobe does not match write data");
    zero_strobe_a:     assert property ($rose(WR_ZERO) |-> !cmd_q.data && $stable(ROW_SEL))
        else $error("write-zero strobe for a one or with moving select");
    strobe_width_a:    assert property ($fell(WR_ONE || WR_ZERO) |-> (width_q >= STROBE_MIN))
        else $error("write strobe shorter than minimum");
    settle_hold_a:     assert property ($fell(WR_ONE || WR_ZERO) |-> sel_still_s ##1 sel_still_s [*8])
        else $error("select dropped before data settled");
    write_answer_a:    assert property (write_taken_s |-> ##[30:60] write_done_s)
        else $error("write answer missing");
    none_reads_zero_a: assert property ((RSP_VALID && RSP_NONE) |-> !RSP_DATA)
        else $error("floating sense reported as a one");

endmodule : csmc_ctrl

// file: dv/csmc_mem_model.sv
// behavioural model of the 16x1 coincident-select latch memory with pin checks
`timescale 1ns/1ns
module csmc_mem_model (
    input  wire logic [3:0]  row,
    input  wire logic [3:0]  col,
    input  wire logic        wr_one,
    input  wire logic        wr_zero,
    input  wire logic [1:0]  mode,
    output wire logic        s1_en,
    output wire logic        s0_en,
    output logic             fault
);
    ////////////////////////////////////////////////////////////////////////////////
    // power-up contents are arbitrary, not cleared
    logic [15:0] mem_q = 16'hA5A5;
    logic [15:0] sel;
    logic        strobe_q = 1'b0;
    realtime     t_rise = -1000.0;
    realtime     t_fall = -1000.0;
    logic        hit1;
    logic        hit0;

    // a cell is chosen only where its row and column are both high; several may be
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            sel[i] = row[i / 4] & col[i % 4];
        end
    end

    // strobes act on selected cells only; reads leave cells alone
    always @(wr_one or wr_zero or sel) begin
        if (wr_one === 1'b1) begin
            mem_q = mem_q | sel;
        end else if (wr_zero === 1'b1) begin
            mem_q = mem_q & ~sel;
        end
    end

    // open-collector senses: enables only, pull-ups live outside; mode 1 mutes, 2 swaps
    assign hit1  = |(sel & mem_q);
    assign hit0  = |(sel & ~mem_q);
    assign s1_en = (mode != 2'h1) & ((mode == 2'h2) ? hit0 : hit1);
    assign s0_en = (mode != 2'h1) & ((mode == 2'h2) ? hit1 : hit0);

    // strobe width, hold of selects after strobe, and strobe exclusivity
    initial fault = 1'b0;
    always @(wr_one or wr_zero) begin
        if ((wr_one === 1'b1 || wr_zero === 1'b1) && !strobe_q) begin
            t_rise   = $realtime;
            strobe_q = 1'b1;
        end else if (wr_one !== 1'b1 && wr_zero !== 1'b1 && strobe_q) begin
            if ($realtime - t_rise < 100.0) fault = 1'b1;
            t_fall   = $realtime;
            strobe_q = 1'b0;
        end
        if (wr_one === 1'b1 && wr_zero === 1'b1) fault = 1'b1;
    end
    always @(sel) begin
        if (strobe_q || $realtime - t_fall < 35.0) fault = 1'b1;
    end
endmodule : csmc_mem_model

// file: dv/csmc_ctrl_tb.sv
// self-checking testbench for the coincident-select memory controller
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module csmc_ctrl_tb;
    logic        MCLK = 1'b0;
    logic        SRST = 1'b1;
    logic        CMD_VALID = 1'b0;
    logic        CMD_WRITE = 1'b0;
    logic [3:0]  CMD_ADDR = 4'h0;
    logic        CMD_DATA = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [15:0] exp_q = 16'hA5A5;
    wire         CMD_READY, RSP_VALID, RSP_DATA, RSP_NONE, RSP_MISMATCH, WR_ONE, WR_ZERO;
    wire  [3:0]  ROW_SEL, COL_SEL;
    wire         s1_en, s0_en, fault;
    wire         SENSE_ONE_N  = ~s1_en;  // pull-up when released
    wire         SENSE_ZERO_N = ~s0_en;
    int          failures = 0;
    int          n_compared = 0;
    localparam int WR_LAT = csmc_pkg::SETUP_CYC + csmc_pkg::STROBE_CYC + csmc_pkg::SETTLE_CYC;
    localparam int RD_LAT = csmc_pkg::SETUP_CYC + csmc_pkg::ACCESS_CYC;

    csmc_ctrl csmc_ctrl_inst (.MCLK(MCLK), .SRST(SRST), .CMD_VALID(CMD_VALID), .CMD_WRITE(CMD_WRITE),
        .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID),
        .RSP_DATA(RSP_DATA), .RSP_NONE(RSP_NONE), .RSP_MISMATCH(RSP_MISMATCH), .ROW_SEL(ROW_SEL),
        .COL_SEL(COL_SEL), .WR_ONE(WR_ONE), .WR_ZERO(WR_ZERO), .SENSE_ONE_N(SENSE_ONE_N),
        .SENSE_ZERO_N(SENSE_ZERO_N));
    csmc_mem_model csmc_mem_model_inst (.row(ROW_SEL), .col(COL_SEL), .wr_one(WR_ONE),
        .wr_zero(WR_ZERO), .mode(mode), .s1_en(s1_en), .s0_en(s0_en), .fault(fault));

    ////////////////////////////////////////////////////////////////////////////////
    // clock at 4 ns
    initial forever #2 MCLK = ~MCLK;

    // pin watcher: at most one row and one column line high, strobes only with a selection, never both
    always @(negedge MCLK) begin
        if (!SRST) begin
            `CHK($countones(ROW_SEL) <= 1 && $countones(COL_SEL) <= 1, 1'b1)
            `CHK((WR_ONE | WR_ZERO) & ~((|ROW_SEL) & (|COL_SEL)), 1'b0)
            `CHK(WR_ONE & WR_ZERO, 1'b0)
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // closing report
    task automatic print_verdict();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // one command, entered at a falling edge; returns at the answer's falling edge
    task automatic do_cmd(input logic w, input logic [3:0] a, input logic d, output int lat);
        int n;
        n = 0;
        CMD_VALID = 1'b1;
        CMD_WRITE = w;
        CMD_ADDR  = a;
        CMD_DATA  = d;
        while (CMD_READY !== 1'b1) begin
            @(negedge MCLK);
            n++;
            if (n > 100) begin failures++; print_verdict(); end
        end
        @(negedge MCLK);
        CMD_VALID = 1'b0;
        lat = 0;
        while (RSP_VALID !== 1'b1) begin
            @(negedge MCLK);
            lat++;
            if (lat > 100) begin failures++; print_verdict(); end
        end
    endtask : do_cmd

    // answer fields and latency against expectation
    task automatic expect_rsp(input int lat, input int elat, input logic d, input logic none, input logic mis);
        `CHK(lat, elat)
        if (!none) `CHK(RSP_DATA, d)
        `CHK(RSP_NONE, none)
        `CHK(RSP_MISMATCH, mis)
        `CHK(CMD_READY, 1'b1)
    endtask : expect_rsp

    ////////////////////////////////////////////////////////////////////////////////
    // reset: outputs quiet, ready on the first edge after release, senses idle high
    task automatic t_reset();
        SRST = 1'b1;
        repeat (2) @(negedge MCLK);
        `CHK({CMD_READY, RSP_VALID, RSP_DATA, RSP_NONE, RSP_MISMATCH, ROW_SEL, COL_SEL, WR_ONE, WR_ZERO}, 15'h0000)
        SRST = 1'b0;
        @(negedge MCLK);
        `CHK(CMD_READY, 1'b1)
        `CHK({SENSE_ONE_N, SENSE_ZERO_N}, 2'h3)
    endtask : t_reset

    // back-to-back writes of every word; the other fifteen must not move
    task automatic t_write_all();
        int lat;
        for (int a = 0; a < 16; a++) begin
            do_cmd(1'b1, a[3:0], a[0] ^ a[3], lat);
            exp_q[a] = a[0] ^ a[3];
            expect_rsp(lat, WR_LAT, a[0] ^ a[3], 1'b0, 1'b0);
            `CHK(csmc_mem_model_inst.mem_q, exp_q)
        end
    endtask : t_write_all

    // every word read twice in a row; contents survive reading
    task automatic t_read_all();
        int lat;
        for (int a = 0; a < 32; a++) begin
            do_cmd(1'b0, a[4:1], 1'b0, lat);
            expect_rsp(lat, RD_LAT, exp_q[a[4:1]], 1'b0, 1'b0);
            `CHK(csmc_mem_model_inst.mem_q, exp_q)
        end
        `CHK({SENSE_ONE_N, SENSE_ZERO_N}, 2'h3)
    endtask : t_read_all

    // overwrite a one with a zero and a zero with a one, then read both back
    task automatic t_overwrite();
        int lat;
        do_cmd(1'b1, 4'h1, 1'b0, lat);
        expect_rsp(lat, WR_LAT, 1'b0, 1'b0, 1'b0);
        do_cmd(1'b1, 4'h2, 1'b1, lat);
        expect_rsp(lat, WR_LAT, 1'b1, 1'b0, 1'b0);
        exp_q[1] = 1'b0;
        exp_q[2] = 1'b1;
        `CHK(csmc_mem_model_inst.mem_q, exp_q)
        do_cmd(1'b0, 4'h1, 1'b0, lat);
        expect_rsp(lat, RD_LAT, 1'b0, 1'b0, 1'b0);
        do_cmd(1'b0, 4'h2, 1'b0, lat);
        expect_rsp(lat, RD_LAT, 1'b1, 1'b0, 1'b0);
    endtask : t_overwrite

    // undriven sense nodes, then swapped senses, are reported
    task automatic t_bad_sense();
        int lat;
        mode = 2'h1;
        do_cmd(1'b0, 4'h6, 1'b0, lat);
        expect_rsp(lat, RD_LAT, 1'b0, 1'b1, 1'b1);
        mode = 2'h2;
        do_cmd(1'b0, 4'h9, 1'b0, lat);
        expect_rsp(lat, RD_LAT, ~exp_q[9], 1'b0, 1'b1);
        mode = 2'h0;
        do_cmd(1'b0, 4'h9, 1'b0, lat);
        expect_rsp(lat, RD_LAT, exp_q[9], 1'b0, 1'b0);
    endtask : t_bad_sense

    // reset mid-run: answers quiet again, shadow forgets, so a swapped read is no mismatch
    task automatic t_mid_reset();
        int lat;
        t_reset();
        mode = 2'h2;
        do_cmd(1'b0, 4'h9, 1'b0, lat);
        expect_rsp(lat, RD_LAT, ~exp_q[9], 1'b0, 1'b0);
        mode = 2'h0;
    endtask : t_mid_reset

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        t_reset();
        t_write_all();
        t_read_all();
        t_overwrite();
        t_bad_sense();
        t_mid_reset();
        `CHK(fault, 1'b0)
        print_verdict();
    end
endmodule : csmc_ctrl_tb
